// ---- rtl/dvp_ctrl.sv ----
// DAC digital volume, soft-stepping, pop-reduction sequencing and analog volume decode
`timescale 1ns/1ps
module dvp_ctrl #(
	parameter int CYCLES_PER_US = dvp_pkg::CYCLES_PER_US
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	input wire logic [1:0] VOL_LINK_MODE,
	input wire logic [1:0] SOFT_STEP_MODE,
	input wire logic SAMPLE_TICK,
	input wire logic DRV_PWR_REQ,
	output logic DRV_RAMP_ACTIVE,
	output logic DRV_RAMP_STEP,
	output logic DRV_READY,
	output logic WEAK_CM_BANDGAP_SEL,
	output logic DAC_L_MUTE,
	output logic [6:0] DAC_L_ATTEN,
	output logic DAC_R_MUTE,
	output logic [6:0] DAC_R_ATTEN,
	output logic DAC_VOL_SETTLED,
	input wire logic [dvp_pkg::ANA_CHANNELS-1:0][6:0] ANA_VOL_CODE,
	output logic [dvp_pkg::ANA_CHANNELS-1:0][9:0] ANA_ATTEN_TENTHS,
	output logic [dvp_pkg::ANA_CHANNELS-1:0] ANA_MUTE
);
	import dvp_pkg::*;

	typedef struct packed {
		dvp_pop_state_t pop;
		logic [2:0] steps;
		logic step_pulse;
		logic [7:0] pop_reg;
		logic [7:0] l_reg;
		logic [7:0] r_reg;
		logic [7:0] rdata;
		logic [6:0] cur_l;
		logic [6:0] cur_r;
		logic l_mute;
		logic r_mute;
		logic half;
	} dvp_ctrl_s_t;

	dvp_ctrl_s_t st;
	dvp_ctrl_s_t next_st;
	logic tmr_start;
	logic [US_W-1:0] tmr_load;
	logic tmr_done;
	logic [7:0] eff_l;
	logic [7:0] eff_r;
	logic step_now;

	// Moves a current attenuation one code toward its target
	function automatic logic [6:0] dvp_step_toward(input logic [6:0] cur, input logic [6:0] tgt);
		if (cur < tgt) begin
			dvp_step_toward = cur + 7'h01;
		end else if (cur > tgt) begin
			dvp_step_toward = cur - 7'h01;
		end else begin
			dvp_step_toward = cur;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	dvp_us_timer #(
		.CYCLES_PER_US(CYCLES_PER_US)
	) u_timer (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.start(tmr_start),
		.load_us(tmr_load),
		.done(tmr_done)
	);

	// RL10 - one decoder per input
	// RL11 - seven independent controls
	genvar gi;
	generate
		for (gi = 0; gi < ANA_CHANNELS; gi++) begin : g_lut
			dvp_vol_lut u_lut (
				.clk(SYS_CLK),
				.rst_n(RST_N),
				.code(ANA_VOL_CODE[gi]),
				.atten_tenths(ANA_ATTEN_TENTHS[gi]),
				.mute(ANA_MUTE[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		// RL14 - volume link selection
		if (VOL_LINK_MODE == LINK_L_FOLLOWS_R) begin
			eff_l = st.r_reg;
			eff_r = st.r_reg;
		end else if (VOL_LINK_MODE == LINK_R_FOLLOWS_L) begin
			eff_l = st.l_reg;
			eff_r = st.l_reg;
		end else begin
			eff_l = st.l_reg;
			eff_r = st.r_reg;
		end
		// RL15 - soft-step pacing
		if (SOFT_STEP_MODE == SOFT_EVERY_SAMPLE) begin
			step_now = SAMPLE_TICK;
		end else if (SOFT_STEP_MODE == SOFT_EVERY_TWO) begin
			step_now = SAMPLE_TICK & st.half;
		end else begin
			step_now = 1'b0;
		end
	end

	always_comb begin
		next_st = st;
		next_st.step_pulse = 1'b0;
		tmr_start = 1'b0;
		tmr_load = '0;

		// Register writes; reserved bit 0 is stored as written
		if (REG_WR) begin
			if (REG_ADDR == POP_REG_OFS) begin
				next_st.pop_reg = REG_WDATA;
			end else if (REG_ADDR == LEFT_VOL_OFS) begin
				next_st.l_reg = REG_WDATA;
			end else if (REG_ADDR == RIGHT_VOL_OFS) begin
				next_st.r_reg = REG_WDATA;
			end
		end

		// Reads answer one cycle later, unmapped offsets read zero
		if (REG_RD) begin
			if (REG_ADDR == POP_REG_OFS) begin
				next_st.rdata = st.pop_reg;
			end else if (REG_ADDR == LEFT_VOL_OFS) begin
				next_st.rdata = st.l_reg;
			end else if (REG_ADDR == RIGHT_VOL_OFS) begin
				next_st.rdata = st.r_reg;
			end else begin
				next_st.rdata = 8'h00;
			end
		end

		// RL6 - left mute, immediate
		next_st.l_mute = eff_l[MUTE_BIT];
		// RL8 - right mute, immediate
		next_st.r_mute = eff_r[MUTE_BIT];

		if (SAMPLE_TICK) begin
			next_st.half = ~st.half;
		end
		// RL15 - disabled or reserved jumps
		if (SOFT_STEP_MODE != SOFT_EVERY_SAMPLE && SOFT_STEP_MODE != SOFT_EVERY_TWO) begin
			next_st.cur_l = eff_l[ATTEN_MSB:0];
			next_st.cur_r = eff_r[ATTEN_MSB:0];
		end else if (step_now) begin
			// RL7 - left half-dB steps
			next_st.cur_l = dvp_step_toward(st.cur_l, eff_l[ATTEN_MSB:0]);
			// RL9 - right half-dB steps
			next_st.cur_r = dvp_step_toward(st.cur_r, eff_r[ATTEN_MSB:0]);
		end

		// Dropping the request always returns the driver to rest
		case (st.pop)
			POP_IDLE: begin
				if (DRV_PWR_REQ) begin
					// RL1 - start power-on wait
					tmr_start = 1'b1;
					tmr_load = dvp_delay_us(st.pop_reg[DELAY_MSB:DELAY_LSB]);
					next_st.pop = POP_DELAY;
				end
			end
			POP_DELAY: begin
				if (!DRV_PWR_REQ) begin
					next_st.pop = POP_IDLE;
				end else if (tmr_done) begin
					// RL3 - first ramp step
					tmr_start = 1'b1;
					tmr_load = dvp_ramp_us(st.pop_reg[RAMP_MSB:RAMP_LSB]);
					next_st.steps = 3'h0;
					next_st.pop = POP_RAMP;
				end
			end
			POP_RAMP: begin
				if (!DRV_PWR_REQ) begin
					next_st.pop = POP_IDLE;
				end else if (tmr_done) begin
					next_st.step_pulse = 1'b1;
					if (st.steps == RAMP_LAST) begin
						next_st.pop = POP_ON;
					end else begin
						// RL3 - next ramp step
						tmr_start = 1'b1;
						tmr_load = dvp_ramp_us(st.pop_reg[RAMP_MSB:RAMP_LSB]);
						next_st.steps = st.steps + 3'h1;
					end
				end
			end
			POP_ON: begin
				if (!DRV_PWR_REQ) begin
					next_st.pop = POP_IDLE;
				end
			end
			default: begin
				next_st.pop = POP_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st.pop <= POP_IDLE;
			st.steps <= 3'h0;
			st.step_pulse <= 1'b0;
			st.pop_reg <= POP_REG_RESET;
			st.l_reg <= LEFT_VOL_RESET;
			st.r_reg <= RIGHT_VOL_RESET;
			st.rdata <= 8'h00;
			st.cur_l <= LEFT_VOL_RESET[ATTEN_MSB:0];
			st.cur_r <= RIGHT_VOL_RESET[ATTEN_MSB:0];
			st.l_mute <= 1'b1;
			st.r_mute <= 1'b1;
			st.half <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign REG_RDATA = st.rdata;
	// RL4 - common-mode source select
	assign WEAK_CM_BANDGAP_SEL = st.pop_reg[CM_SEL_BIT];
	assign DRV_RAMP_ACTIVE = (st.pop == POP_RAMP);
	assign DRV_RAMP_STEP = st.step_pulse;
	assign DRV_READY = (st.pop == POP_ON);
	assign DAC_L_MUTE = st.l_mute;
	assign DAC_R_MUTE = st.r_mute;
	assign DAC_L_ATTEN = st.cur_l;
	assign DAC_R_ATTEN = st.cur_r;
	assign DAC_VOL_SETTLED = (st.cur_l == st.l_reg[ATTEN_MSB:0] || VOL_LINK_MODE == LINK_L_FOLLOWS_R)
		&& (st.cur_l == eff_l[ATTEN_MSB:0]) && (st.cur_r == eff_r[ATTEN_MSB:0]);

endmodule

// ---- rtl/dvp_pkg.sv ----
// Constants, types and decode functions for the DAC volume and pop control block
// Behaviour
// RL1 - Delay code 0-11 picks power-on wait
// RL2 - Software never writes delay codes 12-15
// RL3 - Ramp step code gives 0/1/2/4 ms
// RL4 - Bit 1 selects band-gap common-mode source
// RL5 - Software writes zero to pop bit 0
// RL6 - Left mute bit, resets muted
// RL7 - Left attenuation 0.5 dB per code
// RL8 - Right mute bit, resets muted
// RL9 - Right attenuation same as left
// RL10 - Each analog input gets volume control
// RL11 - Up to seven controls per input
// RL12 - Output volume follows fixed lookup, 0.5 dB per code up to code 36
// RL13 - Code 117 is -78.3 dB, above mutes
// RL14 - Link mode makes one channel follow
// RL15 - Soft-step per one or two samples
package dvp_pkg;

	////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] POP_REG_OFS = 8'h2a;
	localparam logic [7:0] LEFT_VOL_OFS = 8'h2b;
	localparam logic [7:0] RIGHT_VOL_OFS = 8'h2c;
	localparam logic [7:0] POP_REG_RESET = 8'h00;
	localparam logic [7:0] LEFT_VOL_RESET = 8'h80;
	localparam logic [7:0] RIGHT_VOL_RESET = 8'h80;

	localparam int DELAY_MSB = 7;
	localparam int DELAY_LSB = 4;
	localparam int RAMP_MSB = 3;
	localparam int RAMP_LSB = 2;
	localparam int CM_SEL_BIT = 1;
	localparam int MUTE_BIT = 7;
	localparam int ATTEN_MSB = 6;

	////////////////////////////////////////////////////////////////////////
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_US = 1000;
	localparam int US_PER_MS = 1000;
	localparam int CYCLES_PER_US = NS_PER_US / CLK_PERIOD_NS;
	localparam int US_W = 22;
	localparam int RAMP_STEPS = 8;
	localparam logic [2:0] RAMP_LAST = 3'h7;

	localparam logic [1:0] LINK_L_FOLLOWS_R = 2'h1;
	localparam logic [1:0] LINK_R_FOLLOWS_L = 2'h2;
	localparam logic [1:0] SOFT_EVERY_SAMPLE = 2'h0;
	localparam logic [1:0] SOFT_EVERY_TWO = 2'h1;

	localparam logic [6:0] ANA_LINEAR_LAST = 7'h24;
	localparam logic [6:0] ANA_TABLE_FIRST = 7'h47;
	localparam logic [6:0] ANA_LAST_AUDIBLE = 7'h75;
	localparam int ANA_CHANNELS = 7;

	typedef enum logic [1:0] {POP_IDLE, POP_DELAY, POP_RAMP, POP_ON} dvp_pop_state_t;

	////////////////////////////////////////////////////////////////////////
	// RL1 - delay code decode
	function automatic logic [US_W-1:0] dvp_delay_us(input logic [3:0] code);
		case (code)
			4'h0: dvp_delay_us = 22'h000000;
			4'h1: dvp_delay_us = 22'h00000a;
			4'h2: dvp_delay_us = 22'h000064;
			4'h3: dvp_delay_us = 22'h0003e8;
			4'h4: dvp_delay_us = 22'h0003e8;
			4'h5: dvp_delay_us = 22'h00c350;
			4'h6: dvp_delay_us = 22'h0186a0;
			4'h7: dvp_delay_us = 22'h030d40;
			4'h8: dvp_delay_us = 22'h061a80;
			4'h9: dvp_delay_us = 22'h0c3500;
			4'ha: dvp_delay_us = 22'h1e8480;
			4'hb: dvp_delay_us = 22'h3d0900;
			// RL2 - reserved codes unused
			default: dvp_delay_us = 22'h000000;
		endcase
	endfunction

	// RL3 - ramp step decode
	function automatic logic [US_W-1:0] dvp_ramp_us(input logic [1:0] code);
		case (code)
			2'h0: dvp_ramp_us = 22'h000000;
			2'h1: dvp_ramp_us = 22'(1 * US_PER_MS);
			2'h2: dvp_ramp_us = 22'(2 * US_PER_MS);
			default: dvp_ramp_us = 22'(4 * US_PER_MS);
		endcase
	endfunction

endpackage

// ---- rtl/dvp_us_timer.sv ----
// Microsecond down-counter that pulses once its programmed wait has run out
`timescale 1ns/1ps
module dvp_us_timer #(
	parameter int CYCLES_PER_US = dvp_pkg::CYCLES_PER_US
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [dvp_pkg::US_W-1:0] load_us,
	output logic done
);
	import dvp_pkg::*;

	typedef struct packed {
		logic busy;
		logic done;
		logic [US_W-1:0] cnt;
		logic [15:0] pre;
	} dvp_tmr_s_t;

	dvp_tmr_s_t st;
	dvp_tmr_s_t next_st;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		// A new start overrides any wait still running
		if (start) begin
			next_st.busy = 1'b1;
			next_st.cnt = load_us;
			next_st.pre = 16'h0000;
		end else if (st.busy) begin
			if (st.cnt == '0) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end else if (st.pre == 16'(CYCLES_PER_US - 1)) begin
				next_st.pre = 16'h0000;
				next_st.cnt = st.cnt - 1'b1;
			end else begin
				next_st.pre = st.pre + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign done = st.done;

endmodule

// ---- rtl/dvp_vol_lut.sv ----
// Output-stage analog volume lookup: code to attenuation in tenths of a dB
`timescale 1ns/1ps
module dvp_vol_lut (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [6:0] code,
	output logic [9:0] atten_tenths,
	output logic mute
);
	import dvp_pkg::*;

	// Irregular tail, codes 71 to 117
	localparam logic [9:0] TAIL [0:46] = '{
		10'h165, 10'h169, 10'h16f, 10'h173, 10'h179, 10'h17e, 10'h183, 10'h188,
		10'h18d, 10'h192, 10'h197, 10'h19c, 10'h1a1, 10'h1a6, 10'h1ab, 10'h1b0,
		10'h1b6, 10'h1bb, 10'h1c0, 10'h1c4, 10'h1ca, 10'h1ce, 10'h1d3, 10'h1da,
		10'h1df, 10'h1e2, 10'h1e7, 10'h1ed, 10'h1f4, 10'h1f7, 10'h1fe, 10'h202,
		10'h206, 10'h20a, 10'h20f, 10'h219, 10'h21e, 10'h229, 10'h237, 10'h247,
		10'h25a, 10'h273, 10'h283, 10'h296, 10'h2af, 10'h2d2, 10'h30f};

	typedef struct packed {
		logic [9:0] atten;
		logic mute;
	} dvp_lut_s_t;

	dvp_lut_s_t st;
	dvp_lut_s_t next_st;
	logic [9:0] five_code;
	logic [6:0] tail_idx;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		five_code = 10'({3'h0, code} * 10'h005);
		tail_idx = code - ANA_TABLE_FIRST;
		next_st.mute = 1'b0;
		// RL12 - exact half-dB span
		if (code <= ANA_LINEAR_LAST) begin
			next_st.atten = five_code;
		end else if (code < ANA_TABLE_FIRST) begin
			// Codes 37 to 70 carry one tenth more attenuation than the straight line
			next_st.atten = five_code + 10'h001;
		// RL13 - last audible code
		end else if (code <= ANA_LAST_AUDIBLE) begin
			next_st.atten = TAIL[tail_idx[5:0]];
		end else begin
			// RL13 - top codes mute
			next_st.atten = TAIL[6'h2e];
			next_st.mute = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign atten_tenths = st.atten;
	assign mute = st.mute;

endmodule

// ---- sim/dvp_ctrl_props.sv ----
// Port assertions for the DAC volume and pop control block
`timescale 1ns/1ps
module dvp_ctrl_props #(
	parameter int CYCLES_PER_US = 100
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic [1:0] VOL_LINK_MODE,
	input wire logic [1:0] SOFT_STEP_MODE,
	input wire logic SAMPLE_TICK,
	input wire logic DRV_PWR_REQ,
	input wire logic DRV_RAMP_ACTIVE,
	input wire logic DRV_RAMP_STEP,
	input wire logic DRV_READY,
	input wire logic WEAK_CM_BANDGAP_SEL,
	input wire logic DAC_L_MUTE,
	input wire logic [6:0] DAC_L_ATTEN,
	input wire logic DAC_R_MUTE,
	input wire logic [6:0] DAC_R_ATTEN,
	input wire logic DAC_VOL_SETTLED,
	input wire logic [dvp_pkg::ANA_CHANNELS-1:0][6:0] ANA_VOL_CODE,
	input wire logic [dvp_pkg::ANA_CHANNELS-1:0][9:0] ANA_ATTEN_TENTHS,
	input wire logic [dvp_pkg::ANA_CHANNELS-1:0] ANA_MUTE
);
	import dvp_pkg::*;
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);
	////////////////////////////////////////////////////////////////////////
	// Register lands first, outputs follow one edge later, so link and soft-step must stay off then
	sequence s_wr_l;
		(REG_WR && REG_ADDR == LEFT_VOL_OFS) ##1 (VOL_LINK_MODE == 2'h0 && SOFT_STEP_MODE[1]);
	endsequence
	sequence s_wr_r;
		(REG_WR && REG_ADDR == RIGHT_VOL_OFS) ##1 (VOL_LINK_MODE == 2'h0 && SOFT_STEP_MODE[1]);
	endsequence
	sequence s_linked;
		(VOL_LINK_MODE == LINK_L_FOLLOWS_R && SOFT_STEP_MODE[1]) [*3];
	endsequence
	chk_left_mute_wr: assert property (s_wr_l |=> DAC_L_MUTE == $past(REG_WDATA[7], 2))
		else $error("left mute wrong after write");
	chk_left_atten_wr: assert property (s_wr_l |=> DAC_L_ATTEN == $past(REG_WDATA[6:0], 2))
		else $error("left attenuation wrong after write");
	chk_right_vol_wr: assert property (s_wr_r |=> {DAC_R_MUTE, DAC_R_ATTEN} == $past(REG_WDATA, 2))
		else $error("right volume wrong after write");
	chk_bandgap_sel_wr: assert property (REG_WR && REG_ADDR == POP_REG_OFS
		|=> WEAK_CM_BANDGAP_SEL == $past(REG_WDATA[1]))
		else $error("common-mode source wrong after write");
	chk_link_left_follows: assert property (s_linked |-> {DAC_L_MUTE, DAC_L_ATTEN} == {DAC_R_MUTE, DAC_R_ATTEN})
		else $error("left does not follow right");
	chk_step_on_tick: assert property (!$past(SOFT_STEP_MODE[1]) && DAC_L_ATTEN != $past(DAC_L_ATTEN)
		|-> $past(SAMPLE_TICK))
		else $error("attenuation moved without a tick");
	chk_ana_mute_code: assert property (1'b1 |=> ANA_MUTE[0] == ($past(ANA_VOL_CODE[0]) > ANA_LAST_AUDIBLE))
		else $error("analog mute wrong");
	chk_ana_linear_span: assert property (ANA_VOL_CODE[1] <= ANA_LINEAR_LAST
		|=> ANA_ATTEN_TENTHS[1] == 10'(5 * $past(ANA_VOL_CODE[1])))
		else $error("analog linear attenuation wrong");
	chk_ready_last_step: assert property ($rose(DRV_READY) |-> DRV_RAMP_STEP && $past(DRV_RAMP_ACTIVE))
		else $error("ready without final ramp step");
endmodule

bind dvp_ctrl dvp_ctrl_props #(.CYCLES_PER_US(CYCLES_PER_US)) u_dvp_ctrl_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.VOL_LINK_MODE(VOL_LINK_MODE), .SOFT_STEP_MODE(SOFT_STEP_MODE), .SAMPLE_TICK(SAMPLE_TICK),
	.DRV_PWR_REQ(DRV_PWR_REQ), .DRV_RAMP_ACTIVE(DRV_RAMP_ACTIVE), .DRV_RAMP_STEP(DRV_RAMP_STEP),
	.DRV_READY(DRV_READY), .WEAK_CM_BANDGAP_SEL(WEAK_CM_BANDGAP_SEL), .DAC_L_MUTE(DAC_L_MUTE),
	.DAC_L_ATTEN(DAC_L_ATTEN), .DAC_R_MUTE(DAC_R_MUTE), .DAC_R_ATTEN(DAC_R_ATTEN),
	.DAC_VOL_SETTLED(DAC_VOL_SETTLED), .ANA_VOL_CODE(ANA_VOL_CODE), .ANA_ATTEN_TENTHS(ANA_ATTEN_TENTHS),
	.ANA_MUTE(ANA_MUTE));

// ---- sim/dvp_ctrl_bench.sv ----
// Self-checking bench for the DAC volume and pop control block
`timescale 1ns/1ps
module dvp_ctrl_bench;
	import dvp_pkg::*;
	logic SYS_CLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0, SAMPLE_TICK = 0, DRV_PWR_REQ = 0;
	logic [7:0] REG_ADDR = '0, REG_WDATA = '0, REG_RDATA;
	logic [1:0] VOL_LINK_MODE = '0, SOFT_STEP_MODE = 2'h2;
	logic DRV_RAMP_ACTIVE, DRV_RAMP_STEP, DRV_READY, WEAK_CM_BANDGAP_SEL, DAC_L_MUTE, DAC_R_MUTE, DAC_VOL_SETTLED;
	logic [6:0] DAC_L_ATTEN, DAC_R_ATTEN;
	logic [ANA_CHANNELS-1:0][6:0] ANA_VOL_CODE = '0;
	logic [ANA_CHANNELS-1:0][9:0] ANA_ATTEN_TENTHS;
	logic [ANA_CHANNELS-1:0] ANA_MUTE;
	integer n_mismatch = 0, tests_run = 0, seed = 30263, cyc = 0, k, m, c, t, e;
	logic [7:0] mreg [3];
	logic [31:0] rv;
	// Output-stage attenuation in tenths of a dB for codes 71 to 116
	int ana_tail [46] = '{357, 361, 367, 371, 377, 382, 387, 392, 397, 402, 407, 412, 417, 422, 427, 432,
		438, 443, 448, 452, 458, 462, 467, 474, 479, 482, 487, 493, 500, 503, 510, 514, 518, 522, 527, 537,
		542, 553, 567, 583, 602, 627, 643, 662, 687, 722};
	always #5 SYS_CLK = ~SYS_CLK;
	// One cycle per microsecond keeps the long waits short
	dvp_ctrl #(.CYCLES_PER_US(1)) u_dvp_ctrl (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .VOL_LINK_MODE(VOL_LINK_MODE),
		.SOFT_STEP_MODE(SOFT_STEP_MODE), .SAMPLE_TICK(SAMPLE_TICK), .DRV_PWR_REQ(DRV_PWR_REQ),
		.DRV_RAMP_ACTIVE(DRV_RAMP_ACTIVE), .DRV_RAMP_STEP(DRV_RAMP_STEP), .DRV_READY(DRV_READY),
		.WEAK_CM_BANDGAP_SEL(WEAK_CM_BANDGAP_SEL), .DAC_L_MUTE(DAC_L_MUTE), .DAC_L_ATTEN(DAC_L_ATTEN),
		.DAC_R_MUTE(DAC_R_MUTE), .DAC_R_ATTEN(DAC_R_ATTEN), .DAC_VOL_SETTLED(DAC_VOL_SETTLED),
		.ANA_VOL_CODE(ANA_VOL_CODE), .ANA_ATTEN_TENTHS(ANA_ATTEN_TENTHS), .ANA_MUTE(ANA_MUTE));
	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
		if (a >= POP_REG_OFS && a <= RIGHT_VOL_OFS)
			mreg[a - POP_REG_OFS] = d;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge SYS_CLK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
		@(negedge SYS_CLK);
		chk(REG_RDATA, (a >= POP_REG_OFS && a <= RIGHT_VOL_OFS) ? mreg[a - POP_REG_OFS] : 8'h00);
	endtask
	task automatic ticks(input integer n);
		repeat (n) begin
			@(posedge SYS_CLK);
			SAMPLE_TICK <= 1'b1;
			@(posedge SYS_CLK);
			SAMPLE_TICK <= 1'b0;
			@(posedge SYS_CLK);
		end
		#1;
	endtask
	// Hang guard, well above the longest pop sequence
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		mreg = '{8'h00, 8'h80, 8'h80};
		repeat (5) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		for (k = 0; k < 4; k++)
			rd(POP_REG_OFS + 8'(k));
		$display("reset test done");
		for (k = 0; k < 16; k++) begin
			rv = $random(seed);
			@(posedge SYS_CLK);
			VOL_LINK_MODE <= 2'(k);
			wr(POP_REG_OFS, {1'b0, rv[6:1], 1'b0});
			wr(LEFT_VOL_OFS, rv[15:8]);
			wr(RIGHT_VOL_OFS, rv[23:16]);
			wr(8'h2d, rv[31:24]);
			for (m = 0; m < 4; m++)
				rd(POP_REG_OFS + 8'(m));
			repeat (2) @(posedge SYS_CLK);
			#1;
			chk({DAC_L_MUTE, DAC_L_ATTEN}, mreg[(k % 4 == 1) ? 2 : 1]);
			chk({DAC_R_MUTE, DAC_R_ATTEN}, mreg[(k % 4 == 2) ? 1 : 2]);
			chk(WEAK_CM_BANDGAP_SEL, mreg[0][1]);
		end
		$display("register test done");
		VOL_LINK_MODE <= 2'h0;
		for (m = 0; m < 2; m++) begin
			@(posedge SYS_CLK);
			SOFT_STEP_MODE <= 2'h2;
			wr(LEFT_VOL_OFS, 8'h00);
			// Outputs follow the register one edge late; let the jump to zero land first
			@(posedge SYS_CLK);
			SOFT_STEP_MODE <= 2'(m);
			wr(LEFT_VOL_OFS, 8'h04);
			ticks(2);
			chk({DAC_L_ATTEN, DAC_VOL_SETTLED}, (2 >> m) * 2);
			ticks(6);
			chk({DAC_L_ATTEN, DAC_VOL_SETTLED}, 8'h09);
		end
		$display("soft-step test done");
		for (c = 0; c < 128; c++) begin
			@(posedge SYS_CLK);
			for (k = 0; k < ANA_CHANNELS; k++)
				ANA_VOL_CODE[k] <= 7'(c + 19 * k);
			repeat (2) @(posedge SYS_CLK);
			#1;
			for (k = 0; k < ANA_CHANNELS; k++) begin
				t = (c + 19 * k) % 128;
				chk(ANA_MUTE[k], t > 117);
				e = t < 37 ? 5 * t : t < 71 ? 5 * t + 1 : t < 117 ? ana_tail[t - 71] : 783;
				chk(ANA_ATTEN_TENTHS[k], e);
			end
		end
		$display("analog volume test done");
		for (m = 0; m < 5; m++) begin
			wr(POP_REG_OFS, m < 4 ? {4'(m), 4'h0} : 8'h04);
			c = (m == 1) ? 10 : (m == 2) ? 100 : (m == 3) ? 1000 : 0;
			DRV_PWR_REQ <= 1'b1;
			t = 0;
			while (DRV_RAMP_ACTIVE !== 1'b1 && t < 2000) begin
				@(posedge SYS_CLK);
				#1;
				t++;
			end
			chk(t >= c && t <= c + 6, 1);
			k = 0;
			t = 0;
			while (DRV_READY !== 1'b1 && t < 9000) begin
				@(posedge SYS_CLK);
				#1;
				k += DRV_RAMP_STEP;
				t++;
			end
			chk(k, 8);
			chk(t >= (m == 4 ? 8000 : 0) && t <= (m == 4 ? 8040 : 40), 1);
			@(posedge SYS_CLK);
			DRV_PWR_REQ <= 1'b0;
			repeat (2) @(posedge SYS_CLK);
			#1;
			chk(DRV_READY, 0);
		end
		$display("pop sequence test done");
		end_of_test();
	end
endmodule
